// ===== rtl/flash_seq_pkg.sv
// Package for the serial flash command sequencer.
// Assumes a 250 MHz system clock and an APB register port.
package flash_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int SYS_CLK_MHZ = 250;
  localparam logic [2:0] PH_RISE = 3'h3; // Serial clock goes high after this
  localparam logic [2:0] PH_LAST = 3'h7; // Last system cycle of a bit cell
  localparam int CS_GAP_NS = 32;         // Least select-high time
  localparam int CS_GAP_CYC = (CS_GAP_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] CS_GAP_CNT = 4'(CS_GAP_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Flash command codes
  localparam logic [7:0] CMD_RST_EN = 8'h66;
  localparam logic [7:0] CMD_RST_DEV = 8'h99;
  localparam logic [7:0] CMD_WAKE_ID = 8'hAB;
  localparam logic [7:0] CMD_WR_EN = 8'h06;
  localparam logic [7:0] CMD_RD_SR1 = 8'h05;
  localparam logic [7:0] CMD_WR_SR2 = 8'h31;
  localparam logic [7:0] CMD_FR = 8'h0B;
  localparam logic [7:0] CMD_FR_4B = 8'h0C;
  localparam logic [7:0] CMD_FRD = 8'h3B;
  localparam logic [7:0] CMD_FRD_4B = 8'h3C;
  localparam logic [7:0] CMD_FRQ = 8'h6B;
  localparam logic [7:0] CMD_PW = 8'h02;
  localparam logic [7:0] CMD_PW_4B = 8'h12;
  localparam logic [7:0] CMD_QPW = 8'h32;
  localparam logic [7:0] CMD_SE = 8'h20;
  localparam logic [7:0] CMD_SE_4B = 8'h21;
  localparam logic [7:0] CMD_BE = 8'hD8;
  localparam logic [7:0] CMD_BE_4B = 8'hDC;
  localparam logic [7:0] QE_SR2_VAL = 8'h02; // Quad-enable bit set
  localparam int WIP_BIT = 0;                // Flash busy status bit

  ////////////////////////////////////////////////////////////////////////////
  // Header lengths in serial clocks
  localparam logic [5:0] HB_CMD = 6'h08;
  localparam logic [5:0] HB_3 = 6'h20;
  localparam logic [5:0] HB_4 = 6'h28;
  localparam logic [5:0] HB_DMY = 6'h08;
  localparam logic [5:0] HB_ID = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and register map
  localparam int ADDR_W = 32;
  localparam int BUF_DEPTH = 256;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam int CTRL_4B_BIT = 0;
  localparam logic CTRL_4B_RST = 1'b0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_QUAD_BIT = 1;
  localparam int STAT_BYTE_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_RSTEN = 3'b001, ST_RSTDEV = 3'b010,
    ST_RDONE = 3'b011, ST_WEN = 3'b100, ST_OP = 3'b101,
    ST_POLL = 3'b110
  } st_t;

  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_DUAL = 4'h1, OP_QREAD = 4'h2, OP_PW = 4'h3,
    OP_QPW = 4'h4, OP_SE = 4'h5, OP_BE = 4'h6, OP_ID = 4'h7,
    OP_QE = 4'h8
  } op_t;

  typedef enum logic [2:0] {
    DM_NONE = 3'b000, DM_TXBUF = 3'b001, DM_TXIMM = 3'b010,
    DM_RXSTR = 3'b011, DM_RXID = 3'b100, DM_RXSTAT = 3'b101
  } dm_t;

  // One framed flash transaction
  typedef struct packed {
    logic [47:0] hdr;   // Command, address, dummy, left aligned
    logic [5:0] hbits;  // Header length
    dm_t dm;            // Data phase kind
    logic [2:0] lw;     // Data lanes: 1, 2 or 4
  } frame_t;

endpackage

// ===== rtl/flash_seq_ctrl.sv
// Serial flash command sequencer: user requests in, framed flash
// transactions out. Assumes the flash samples on the rising serial clock
// edge and that all user inputs are on SYS_CLK.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps

module flash_seq_ctrl
  import flash_seq_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // Register bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Operation requests
  input wire logic FAST_READ,
  input wire logic FAST_READ_DUAL,
  input wire logic QUAD_FAST_READ,
  input wire logic PAGE_WRITE,
  input wire logic QUAD_PAGE_WRITE,
  input wire logic SECTOR_ERASE,
  input wire logic LARGE_BLOCK_WIPE_REQUEST,
  input wire logic WAKE_OR_IDENT_REQUEST,
  input wire logic QUAD_ENABLE,
  input wire logic [ADDR_W-1:0] ADDRESS,
  input wire logic READ_ENABLE,
  input wire logic WRITE_ENABLE,
  // Write data and read data
  input wire logic SHIFT_BYTES,
  input wire logic [7:0] DATA_IN,
  output logic BUSY,
  output logic [7:0] DATA_OUT,
  output logic DATA_VALID,
  // Flash pins
  input wire logic MISO,
  input wire logic MISO_1,
  input wire logic MISO_2,
  input wire logic MISO_3,
  output logic SCLK,
  output logic NSS_N,
  output logic MOSI,
  output logic MOSI_1,
  output logic MOSI_2,
  output logic MOSI_3,
  output logic MOSI_OE
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Lane drive for the top bits of a byte; spare lanes idle high
  function automatic logic [3:0] lanes(logic [7:0] b, logic [2:0] lw);
    unique case (lw)
      3'h4: lanes = b[7:4];
      3'h2: lanes = {2'b11, b[7:6]};
      default: lanes = {3'b111, b[7]};
    endcase
  endfunction

  // Serial clocks per byte, minus one
  function automatic logic [2:0] bits_m1(logic [2:0] lw);
    unique case (lw)
      3'h4: bits_m1 = 3'h1;
      3'h2: bits_m1 = 3'h3;
      default: bits_m1 = 3'h7;
    endcase
  endfunction

  // Shift received lanes into a byte
  function automatic logic [7:0] shift_in(logic [7:0] r, logic [3:0] s,
                                          logic [2:0] lw);
    unique case (lw)
      3'h4: shift_in = {r[3:0], s};
      3'h2: shift_in = {r[5:0], s[1:0]};
      default: shift_in = {r[6:0], s[0]};
    endcase
  endfunction

  // Command-only frame
  function automatic frame_t mk_plain(logic [7:0] c, dm_t dm);
    frame_t f;
    f.hdr = {c, 40'h00_0000_0000};
    f.hbits = HB_CMD;
    f.dm = dm;
    f.lw = 3'h1;
    return f;
  endfunction

  // Main frame of an operation
  function automatic frame_t mk_op(op_t op, logic [ADDR_W-1:0] a,
                                   logic four);
    frame_t f;
    logic [7:0] c;
    logic dmy;
    logic f4;
    c = CMD_FR;
    dmy = 1'b0;
    f4 = four;
    f.dm = DM_NONE;
    f.lw = 3'h1;
    unique case (op)
      OP_READ: begin
        c = four ? CMD_FR_4B : CMD_FR;
        dmy = 1'b1;
        f.dm = DM_RXSTR;
      end
      OP_DUAL: begin
        c = four ? CMD_FRD_4B : CMD_FRD;
        dmy = 1'b1;
        f.dm = DM_RXSTR;
        f.lw = 3'h2;
      end
      OP_QREAD: begin
        c = CMD_FRQ;
        dmy = 1'b1;
        f.dm = DM_RXSTR;
        f.lw = 3'h4;
      end
      OP_PW: begin
        c = four ? CMD_PW_4B : CMD_PW;
        f.dm = DM_TXBUF;
      end
      OP_QPW: begin
        c = CMD_QPW;
        f4 = 1'b0;
        f.dm = DM_TXBUF;
        f.lw = 3'h4;
      end
      OP_SE: c = four ? CMD_SE_4B : CMD_SE;
      OP_BE: c = four ? CMD_BE_4B : CMD_BE;
      default: c = CMD_WAKE_ID;
    endcase
    f.hdr = f4 ? {c, a, 8'h00} : {c, a[23:0], 16'h0000};
    f.hbits = (f4 ? HB_4 : HB_3) + (dmy ? HB_DMY : 6'h00);
    if (op == OP_ID) begin
      f.hdr = {CMD_WAKE_ID, 40'h00_0000_0000};
      f.hbits = HB_ID;
      f.dm = DM_RXID;
    end
    if (op == OP_QE) begin
      f = mk_plain(CMD_WR_SR2, DM_TXIMM);
    end
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  st_t st_q;
  op_t op_q, req_op;
  frame_t frm_q;
  logic [ADDR_W-1:0] addr_q;
  logic go_q, busy_q, quad_on_q, four_q, keep, rst_phase;
  logic req_ok, req_wen;
  logic [3:0] rx_m_q, rx_s_q;
  logic [7:0] page_mem [BUF_DEPTH];
  logic [8:0] wp_q, bidx_q, tx_total;
  logic clr_wp;
  logic act_q, data_q, done_q, sclk_q, nss_q, oe_q, dval_q;
  logic [2:0] ph_q, bc_q;
  logic [5:0] cnt_q;
  logic [3:0] gap_q, mosi_q;
  logic [47:0] hdr_q;
  logic [7:0] txb_q, rxb_q, rx_nb, dout_q, stat_q, src;
  logic is_tx, hdr_done, load_tx, fin;
  logic [31:0] prdata_q, rd_val;
  logic pready_q, pslverr_q, acc, hit;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for the flash data lanes
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rx_m_q <= 4'h0;
      rx_s_q <= 4'h0;
    end else begin
      rx_m_q <= {MISO_3, MISO_2, MISO_1, MISO};
      rx_s_q <= rx_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer
  always_ff @(posedge SYS_CLK) begin
    if (SHIFT_BYTES && !wp_q[8]) begin
      page_mem[wp_q[7:0]] <= DATA_IN;
    end
  end

  // Fill pointer, emptied once a buffer program frame is done
  assign clr_wp = (st_q == ST_OP) && done_q &&
                  (op_q == OP_PW || op_q == OP_QPW);

  always_ff @(posedge SYS_CLK) begin
    if (SRST || clr_wp) begin
      wp_q <= 9'h000;
    end else if (SHIFT_BYTES && !wp_q[8]) begin
      wp_q <= wp_q + 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request decode, fixed priority
  always_comb begin
    req_ok = 1'b1;
    req_wen = 1'b0;
    req_op = OP_READ;
    if (QUAD_ENABLE) begin
      req_op = OP_QE;
      req_wen = 1'b1;
    end else if (WAKE_OR_IDENT_REQUEST) begin
      req_op = OP_ID;
    end else if (FAST_READ && READ_ENABLE) begin
      req_op = OP_READ;
    end else if (FAST_READ_DUAL && READ_ENABLE) begin
      req_op = OP_DUAL;
    end else if (QUAD_FAST_READ && READ_ENABLE) begin
      req_op = OP_QREAD;
    end else if (WRITE_ENABLE) begin
      req_wen = 1'b1;
      if (PAGE_WRITE) begin
        req_op = OP_PW;
      end else if (QUAD_PAGE_WRITE) begin
        req_op = OP_QPW;
      end else if (SECTOR_ERASE) begin
        req_op = OP_SE;
      end else if (LARGE_BLOCK_WIPE_REQUEST) begin
        req_op = OP_BE;
      end else begin
        req_ok = 1'b0;
      end
    end else begin
      req_ok = 1'b0;
    end
  end

  // Reset restarts the sequence unless it is already in it
  assign rst_phase = st_q inside {ST_RSTEN, ST_RSTDEV, ST_RDONE};
  assign keep = !SRST || rst_phase;

  ////////////////////////////////////////////////////////////////////////////
  // Operation sequencer
  always_ff @(posedge SYS_CLK) begin
    if (keep) begin
      go_q <= 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          if (req_ok) begin
            op_q <= req_op;
            addr_q <= ADDRESS;
            busy_q <= 1'b1;
            go_q <= 1'b1;
            if (req_wen) begin
              st_q <= ST_WEN;
              frm_q <= mk_plain(CMD_WR_EN, DM_NONE);
            end else begin
              st_q <= ST_OP;
              frm_q <= mk_op(req_op, ADDRESS, four_q);
            end
          end
        end
        ST_RSTEN: begin
          if (done_q) begin
            st_q <= ST_RSTDEV;
            frm_q <= mk_plain(CMD_RST_DEV, DM_NONE);
            go_q <= 1'b1;
          end
        end
        ST_RSTDEV: begin
          if (done_q) begin
            st_q <= ST_RDONE;
          end
        end
        ST_RDONE: begin
          if (!SRST) begin
            st_q <= ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        ST_WEN: begin
          if (done_q) begin
            st_q <= ST_OP;
            frm_q <= mk_op(op_q, addr_q, four_q);
            go_q <= 1'b1;
          end
        end
        ST_OP: begin
          if (done_q) begin
            if (op_q inside {OP_PW, OP_QPW, OP_SE, OP_BE, OP_QE}) begin
              st_q <= ST_POLL;
              frm_q <= mk_plain(CMD_RD_SR1, DM_RXSTAT);
              go_q <= 1'b1;
            end else begin
              st_q <= ST_IDLE;
              busy_q <= 1'b0;
            end
          end
        end
        ST_POLL: begin
          if (done_q) begin
            if (stat_q[WIP_BIT]) begin
              go_q <= 1'b1;
            end else begin
              st_q <= ST_IDLE;
              busy_q <= 1'b0;
              if (op_q == OP_QE) begin
                quad_on_q <= 1'b1;
              end
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end else begin
      st_q <= ST_RSTEN;
      frm_q <= mk_plain(CMD_RST_EN, DM_NONE);
      go_q <= 1'b1;
      busy_q <= 1'b1;
      op_q <= OP_READ;
      addr_q <= '0;
      quad_on_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine step decisions
  always_comb begin
    is_tx = frm_q.dm inside {DM_TXBUF, DM_TXIMM};
    tx_total = (frm_q.dm == DM_TXIMM) ? 9'h001 : wp_q;
    src = (frm_q.dm == DM_TXIMM) ? QE_SR2_VAL : page_mem[bidx_q[7:0]];
    hdr_done = !data_q && (cnt_q == 6'h00);
    rx_nb = shift_in(rxb_q, rx_s_q, frm_q.lw);
    load_tx = is_tx && (bidx_q != tx_total) &&
              (hdr_done || (data_q && bc_q == 3'h0));
    fin = (hdr_done && (frm_q.dm == DM_NONE ||
                        (is_tx && bidx_q == tx_total))) ||
          (data_q && is_tx && bc_q == 3'h0 && bidx_q == tx_total) ||
          (data_q && !is_tx && bc_q == 3'h0 &&
           (frm_q.dm != DM_RXSTR || !READ_ENABLE));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine: serial clock of eight system cycles, select framing
  always_ff @(posedge SYS_CLK) begin
    if (keep) begin
      done_q <= 1'b0;
      dval_q <= 1'b0;
      if (!act_q) begin
        if (gap_q != 4'h0) begin
          gap_q <= gap_q - 4'h1;
          if (gap_q == 4'h1) begin
            done_q <= 1'b1;
          end
        end else if (go_q) begin
          act_q <= 1'b1;
          nss_q <= 1'b0;
          oe_q <= 1'b1;
          ph_q <= 3'h0;
          data_q <= 1'b0;
          bidx_q <= 9'h000;
          mosi_q <= lanes(frm_q.hdr[47:40], 3'h1);
          hdr_q <= frm_q.hdr << 1;
          cnt_q <= frm_q.hbits - 6'h01;
        end
      end else begin
        ph_q <= ph_q + 3'h1;
        if (ph_q == PH_RISE) begin
          sclk_q <= 1'b1;
        end
        if (ph_q == PH_LAST) begin
          sclk_q <= 1'b0;
          if (data_q && !is_tx) begin
            rxb_q <= rx_nb;
            if (bc_q == 3'h0) begin
              if (frm_q.dm == DM_RXSTAT) begin
                stat_q <= rx_nb;
              end else begin
                dout_q <= rx_nb;
                dval_q <= 1'b1;
              end
            end
          end
          if (fin) begin
            act_q <= 1'b0;
            nss_q <= 1'b1;
            oe_q <= 1'b0;
            mosi_q <= 4'hF;
            data_q <= 1'b0;
            gap_q <= CS_GAP_CNT;
          end else if (!data_q && cnt_q != 6'h00) begin
            mosi_q <= lanes(hdr_q[47:40], 3'h1);
            hdr_q <= hdr_q << 1;
            cnt_q <= cnt_q - 6'h01;
          end else if (load_tx) begin
            data_q <= 1'b1;
            mosi_q <= lanes(src, frm_q.lw);
            txb_q <= src << frm_q.lw;
            bidx_q <= bidx_q + 9'h001;
            bc_q <= bits_m1(frm_q.lw);
          end else if (hdr_done) begin
            data_q <= 1'b1;
            oe_q <= 1'b0;
            bc_q <= bits_m1(frm_q.lw);
          end else if (is_tx) begin
            mosi_q <= lanes(txb_q, frm_q.lw);
            txb_q <= txb_q << frm_q.lw;
            bc_q <= bc_q - 3'h1;
          end else begin
            bc_q <= (bc_q == 3'h0) ? bits_m1(frm_q.lw) : bc_q - 3'h1;
          end
        end
      end
    end else begin
      act_q <= 1'b0;
      data_q <= 1'b0;
      done_q <= 1'b0;
      sclk_q <= 1'b0;
      nss_q <= 1'b1;
      oe_q <= 1'b0;
      mosi_q <= 4'hF;
      dval_q <= 1'b0;
      gap_q <= 4'h0;
      ph_q <= 3'h0;
      bc_q <= 3'h0;
      cnt_q <= 6'h00;
      bidx_q <= 9'h000;
      hdr_q <= '0;
      txb_q <= 8'h00;
      rxb_q <= 8'h00;
      dout_q <= 8'h00;
      stat_q <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: control and status words, one wait state
  assign acc = PSEL && PENABLE && !pready_q;
  assign hit = (PADDR == REG_CTRL) || (PADDR == REG_STAT);

  // Read value of the addressed word
  always_comb begin
    rd_val = 32'h0000_0000;
    if (PADDR == REG_CTRL) begin
      rd_val[CTRL_4B_BIT] = four_q;
    end else if (PADDR == REG_STAT) begin
      rd_val[STAT_BUSY_BIT] = busy_q;
      rd_val[STAT_QUAD_BIT] = quad_on_q;
      rd_val[STAT_BYTE_LSB +: 8] = dout_q;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      four_q <= CTRL_4B_RST;
    end else begin
      pready_q <= acc;
      if (acc) begin
        prdata_q <= PWRITE ? 32'h0000_0000 : rd_val;
        pslverr_q <= !hit;
      end
      if (PSEL && PENABLE && pready_q && PWRITE &&
          PADDR == REG_CTRL) begin
        four_q <= PWDATA[CTRL_4B_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign BUSY = busy_q;
  assign DATA_OUT = dout_q;
  assign DATA_VALID = dval_q;
  assign SCLK = sclk_q;
  assign NSS_N = nss_q;
  assign MOSI = mosi_q[0];
  assign MOSI_1 = mosi_q[1];
  assign MOSI_2 = mosi_q[2];
  assign MOSI_3 = mosi_q[3];
  assign MOSI_OE = oe_q;

endmodule

// ===== sim/flash_seq_ctrl_properties.sv
// Port checker for the flash sequencer.
// Bound onto every flash_seq_ctrl instance, ports matched by name.
`timescale 1ns/1ps
module flash_seq_ctrl_properties (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // Register bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  // User side
  input wire logic FAST_READ,
  input wire logic READ_ENABLE,
  input wire logic BUSY,
  input wire logic DATA_VALID,
  // Flash side
  input wire logic SCLK,
  input wire logic NSS_N,
  input wire logic MOSI_OE
);
  // One clock domain throughout
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);
  ////////////////////////////////////////
  // Reset and register bus
  a_reset_busy: assert property (disable iff (1'b0) SRST |=> BUSY)
    else $error("busy low after reset");
  a_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("no ready after one wait state");
  // User side
  a_valid_pulse: assert property (DATA_VALID |=> !DATA_VALID)
    else $error("data valid longer than one cycle");
  a_read_start: assert property (!BUSY && FAST_READ && READ_ENABLE
    |=> BUSY) else $error("read request not taken");
  a_idle_quiet: assert property (!BUSY |-> NSS_N && !MOSI_OE)
    else $error("flash active while idle");
  a_busy_select: assert property ($rose(BUSY) |=> !NSS_N)
    else $error("select late after busy");
  // Flash framing
  a_sclk_high: assert property ($rose(SCLK) |-> SCLK[*4] ##1 !SCLK)
    else $error("serial clock high time wrong");
  a_idle_sclk: assert property (NSS_N |-> !SCLK)
    else $error("serial clock outside frame");
  a_oe_framed: assert property (MOSI_OE |-> !NSS_N)
    else $error("lanes driven outside frame");
endmodule

bind flash_seq_ctrl flash_seq_ctrl_properties u_flash_seq_ctrl_properties (.*);

// ===== sim/flash_model.sv
// Behavioural serial flash facing the sequencer.
// Samples on rising sclk, drives on falling sclk; busy for two polls.
`timescale 1ns/1ps
module flash_model (
  // Flash pins
  input wire logic clk,
  input wire logic sclk,
  input wire logic nss_n,
  input wire logic mosi,
  output logic [3:0] miso,
  // Last operation frame seen
  output logic [7:0] op_cmd,
  output logic [31:0] op_frm,
  output logic [7:0] op_cnt
);
  logic [7:0] cmd, cnt, hdr;
  logic [31:0] frm;
  logic [3:0] lanes;
  logic [1:0] pend = 2'h0;
  logic drv = 1'b0, tog = 1'b0;
  ////////////////////////////////////////
  // Header length by command
  assign hdr = cmd == 8'h0C ? 8'h30 : cmd == 8'hAB ? 8'h20 :
    cmd == 8'h05 ? 8'h08 : 8'h28;
  // Released lanes toggle every clock
  always @(posedge clk) tog <= ~tog;
  assign miso = drv ? lanes : {4{tog}};
  // Frame start
  always @(negedge nss_n) begin
    cnt = 8'h00;
    cmd = 8'h00;
  end
  // Shift in command and first word
  always @(posedge sclk) if (!nss_n) begin
    if (cnt < 8'h08) cmd = {cmd[6:0], mosi};
    if (cnt < 8'h20) frm = {frm[30:0], mosi};
    cnt = cnt + 8'h01;
  end
  // Data out: status on lane 0, else fixed lane pattern
  always @(negedge sclk) if (!nss_n && cnt >= hdr) begin
    drv = 1'b1;
    lanes = cmd != 8'h05 ? 4'h9 : {3'h0, cnt[2:0] == 3'h7 && pend != 0};
  end
  // Frame end: track write-in-progress and log operations
  always @(posedge nss_n) begin
    drv = 1'b0;
    if (cmd == 8'h06) pend = 2'h2;
    else if (cmd == 8'h05) pend = pend != 0 ? pend - 2'h1 : 2'h0;
    else begin
      op_cmd = cmd;
      op_frm = frm;
      op_cnt = cnt;
    end
  end
endmodule

// ===== sim/flash_seq_ctrl_tb.sv
// Testbench for the flash sequencer: operation table, then refusals.
// Assumes the behavioural flash model on the flash pins.
`timescale 1ns/1ps
module flash_seq_ctrl_tb;
  import flash_seq_pkg::*;
  logic SYS_CLK = 0, SRST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic READ_ENABLE = 1, WRITE_ENABLE = 1, SHIFT_BYTES = 0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, ADDRESS = 32'h00012345, PRDATA, r;
  logic [7:0] DATA_IN = 8'h00, DATA_OUT, op_cmd, op_cnt;
  logic [31:0] op_frm;
  logic [8:0] req = 9'h000;
  logic PREADY, PSLVERR, BUSY, DATA_VALID, SCLK, NSS_N, MOSI_OE, e;
  logic MOSI, MOSI_1, MOSI_2, MOSI_3;
  wire MISO, MISO_1, MISO_2, MISO_3;
  wire FAST_READ, FAST_READ_DUAL, QUAD_FAST_READ, PAGE_WRITE;
  wire QUAD_PAGE_WRITE, SECTOR_ERASE, LARGE_BLOCK_WIPE_REQUEST;
  wire WAKE_OR_IDENT_REQUEST, QUAD_ENABLE;
  int err_count = 0, n_checks = 0, nv = 0, nq = 0, i;
  // Rows: request bit, command, serial clock count, byte held on the output
  int rb[10] = '{8, 0, 1, 2, 7, 0, 5, 6, 3, 4};
  logic [7:0] rc[10] = '{8'h31, 8'h0B, 8'h3B, 8'h6B, 8'hAB, 8'h0C,
    8'h20, 8'hD8, 8'h02, 8'h32};
  logic [7:0] rn[10] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h20, 8'h20, 8'h38, 8'h26};
  logic [7:0] rd[10] = '{8'h00, 8'hFF, 8'h55, 8'h99, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF};
  ////////////////////////////////////////
  // Request bits onto their pins
  assign {QUAD_ENABLE, WAKE_OR_IDENT_REQUEST, LARGE_BLOCK_WIPE_REQUEST,
    SECTOR_ERASE, QUAD_PAGE_WRITE, PAGE_WRITE, QUAD_FAST_READ,
    FAST_READ_DUAL, FAST_READ} = req;
  flash_seq_ctrl u_flash_seq_ctrl (.*);
  flash_model u_flash_model (.clk(SYS_CLK), .sclk(SCLK), .nss_n(NSS_N),
    .mosi(MOSI), .miso({MISO_3, MISO_2, MISO_1, MISO}), .op_cmd(op_cmd),
    .op_frm(op_frm), .op_cnt(op_cnt));
  // Clock and byte-valid counter
  initial begin
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) if (DATA_VALID === 1'b1) nv++;
  // Lane 1 low at a serial clock rise only carries quad data
  always @(posedge SCLK) if (MOSI_1 === 1'b0) nq++;
  // Compare, close, wait helpers
  task chk(input string nm, input logic [31:0] x, g);
    n_checks++;
    if (g !== x) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask
  task test_done;
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task wait_idle;
    int k;
    k = 0;
    do @(posedge SYS_CLK); while (BUSY !== 1'b0 && ++k < 9000);
    if (k == 9000) begin
      err_count++;
      test_done();
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK) PENABLE <= 1;
    for (k = 0; k < 50; k++) begin
      @(posedge SYS_CLK);
      if (PREADY === 1'b1) break;
    end
    if (k == 50) begin
      err_count++;
      test_done();
    end
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task pulse(input int b);
    req <= 9'h001 << b;
    @(posedge SYS_CLK) req <= 9'h000;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge SYS_CLK);
    SRST <= 0;
    @(posedge SYS_CLK);
    chk("busy", 1, BUSY);
    chk("dout", 0, DATA_OUT);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", 0, r);
    wait_idle();
    chk("reset cmd", 8'h99, op_cmd);
    for (i = 0; i < 10; i++) begin
      if (i == 5) apb(1'b1, REG_CTRL, 32'h1);
      if (rn[i] > 8'h20) begin
        SHIFT_BYTES <= 1;
        repeat (3) @(posedge SYS_CLK) DATA_IN <= DATA_IN + 8'h01;
        SHIFT_BYTES <= 0;
      end
      nv = 0;
      nq = 0;
      pulse(rb[i]);
      repeat (450) @(posedge SYS_CLK);
      READ_ENABLE <= 0;
      wait_idle();
      READ_ENABLE <= 1;
      chk("cmd", rc[i], op_cmd);
      chk("dout", rd[i], DATA_OUT);
      chk("valid", i > 0 && i < 6, nv != 0);
      chk("lane1", (i == 9) ? 5 : 0, nq);
      if (rn[i] != 0) chk("bits", rn[i], op_cnt);
      if (rn[i] == 8'h20) chk("frame", {rc[i], ADDRESS[23:0]}, op_frm);
      if (i == 5) apb(1'b1, REG_CTRL, 32'h0);
    end
    apb(1'b0, 12'h008, 32'h0);
    chk("slverr", 1, e);
    chk("unmapped", 0, r);
    pulse(5);
    repeat (5) @(posedge SYS_CLK);
    pulse(0);
    wait_idle();
    chk("busy refusal", 8'h20, op_cmd);
    READ_ENABLE <= 0;
    pulse(0);
    repeat (3) @(posedge SYS_CLK);
    chk("no read", 0, BUSY);
    WRITE_ENABLE <= 0;
    pulse(5);
    repeat (3) @(posedge SYS_CLK);
    chk("no erase", 0, BUSY);
    test_done();
  end
endmodule
